// ==== core/adc_result_pkg.sv ====
// Constants and register map for the converter result register bank
// Contract
// - Each normal slot register holds a 10-bit core result in bits 15..6, read-only to software.
// - The priority register captures each top-priority result in bits 15..6, apart from slots.
// - A new result landing before the previous one was read sets that register's overrun bit 1.
// - Reading a result register clears its overrun flag, unless a deposit lands on the same edge.
// - Every deposit of a result sets that register's stored flag at bit 0.
// - Reading the result clears the stored flag, unless a deposit lands on the same edge.
// - The monitor 0 threshold is a 10-bit field in bits 15..6, always readable, writable only while monitor 0 is disabled.
// - The threshold is compared against the register picked by the monitor 0 select field.
// - The compare runs on each store into the selected register and raises the monitor event.
// - A monitored register overwritten without reads keeps stored and overrun flags set.
package adc_result_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 8;
  localparam int          RES_W           = 10;
  localparam int          RES_LSB         = 6;
  localparam int          RES_MSB         = 15;
  localparam int          OVR_BIT         = 1;
  localparam int          STORED_BIT      = 0;
  localparam int          SLOT_COUNT      = 3;
  localparam logic [7:0]  OFF_SLOT_SIX    = 8'h00;
  localparam logic [7:0]  OFF_SLOT_SEVEN  = 8'h04;
  localparam logic [7:0]  OFF_PRIORITY    = 8'h08;
  localparam logic [7:0]  OFF_THRESHOLD   = 8'h0C;
  localparam logic [7:0]  OFF_MON_CONTROL = 8'h10;
  localparam logic [7:0]  OFF_MON_STATUS  = 8'h14;
  // Monitor control fields
  localparam int          MON_EN_BIT      = 0;
  localparam int          MON_LARGER_BIT  = 1;
  localparam int          MON_SEL_LSB     = 4;
  localparam int          MON_SEL_W       = 2;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam logic [31:0] RESET_VALUE     = 32'h0000_0000;
  typedef enum logic [1:0] {
    SEL_SLOT_SIX  = 2'h0,
    SEL_SLOT_SEVEN = 2'h1,
    SEL_PRIORITY  = 2'h2
  } mon_sel_e;
endpackage : adc_result_pkg

// ==== core/adc_result_regs.sv ====
// Converter result register bank with monitor 0 compare, AXI4-Lite slave
module adc_result_regs (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Converter core side
  input  wire logic        slot6_deposit_i,
  input  wire logic [9:0]  slot6_result_i,
  input  wire logic        slot7_deposit_i,
  input  wire logic [9:0]  slot7_result_i,
  input  wire logic        priority_deposit_i,
  input  wire logic [9:0]  priority_result_i,
  // Monitor event
  output logic             monitor0_event_o,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);
  localparam int N = adc_result_pkg::SLOT_COUNT;

  result_if slot_bus [N] ();

  logic [N-1:0] deposit_v;
  logic [9:0]   result_v [N];
  logic [N-1:0] read_clear_v;
  logic [9:0]   value_v [N];
  logic [N-1:0] stored_v;
  logic [N-1:0] overrun_v;

  assign deposit_v = {priority_deposit_i, slot7_deposit_i, slot6_deposit_i};
  assign result_v[0] = slot6_result_i;
  assign result_v[1] = slot7_result_i;
  assign result_v[2] = priority_result_i;

  // priority result kept in its own slot
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_slot
      assign slot_bus[g].deposit    = deposit_v[g];
      assign slot_bus[g].value_in   = result_v[g];
      assign slot_bus[g].read_clear = read_clear_v[g];
      assign value_v[g]   = slot_bus[g].value;
      assign stored_v[g]  = slot_bus[g].stored;
      assign overrun_v[g] = slot_bus[g].overrun;
      result_slot u_slot (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .slot       (slot_bus[g])
      );
    end
  endgenerate

  // Monitor state
  logic [9:0] monitor0_level;
  logic       monitor0_enable;
  logic       monitor0_larger;
  logic [1:0] monitor0_reg_select;
  logic       monitor0_hit;

  // Write channel: address and data latched independently
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_thr;
  logic        wr_ctl;
  logic        wr_ok;
  logic        wr_thr_lanes;

  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_thr  = aw_addr == adc_result_pkg::OFF_THRESHOLD;
  assign wr_ctl  = aw_addr == adc_result_pkg::OFF_MON_CONTROL;
  assign wr_ok   = wr_thr | wr_ctl;
  // threshold bits 15..6 span lanes 0 and 1
  assign wr_thr_lanes = w_strb[0] & w_strb[1];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held       <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= adc_result_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? adc_result_pkg::RESP_OKAY : adc_result_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      monitor0_level      <= '0;
      monitor0_enable     <= 1'b0;
      monitor0_larger     <= 1'b0;
      monitor0_reg_select <= '0;
    end else if (wr_fire) begin
      // threshold locked while the monitor runs
      if (wr_thr && wr_thr_lanes && !monitor0_enable) begin
        monitor0_level <= w_data[adc_result_pkg::RES_MSB:adc_result_pkg::RES_LSB];
      end
      if (wr_ctl && w_strb[0]) begin
        monitor0_enable     <= w_data[adc_result_pkg::MON_EN_BIT];
        monitor0_larger     <= w_data[adc_result_pkg::MON_LARGER_BIT];
        monitor0_reg_select <= w_data[adc_result_pkg::MON_SEL_LSB +: adc_result_pkg::MON_SEL_W];
      end
    end
  end

  // Monitor compare
  logic       sel_valid;
  logic       sel_deposit;
  logic [9:0] sel_value;
  assign sel_valid   = monitor0_reg_select <= 2'(adc_result_pkg::SEL_PRIORITY);
  assign sel_deposit = sel_valid & deposit_v[monitor0_reg_select];
  assign sel_value   = sel_valid ? result_v[monitor0_reg_select] : 10'h000;
  // compare the incoming value of the chosen register
  assign monitor0_hit = monitor0_enable & sel_deposit &
                        (monitor0_larger ? (sel_value > monitor0_level)
                                         : (sel_value < monitor0_level));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      monitor0_event_o <= 1'b0;
    end else begin
      monitor0_event_o <= monitor0_hit;
    end
  end

  // Read channel
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [1:0]  rd_idx;
  logic        rd_is_slot;
  logic        ar_take;
  assign ar_take    = s_axi_arvalid & s_axi_arready;
  assign rd_is_slot = s_axi_araddr == adc_result_pkg::OFF_SLOT_SIX
                    | s_axi_araddr == adc_result_pkg::OFF_SLOT_SEVEN
                    | s_axi_araddr == adc_result_pkg::OFF_PRIORITY;
  assign rd_idx     = s_axi_araddr[3:2];

  always_comb begin
    rd_word = adc_result_pkg::RESET_VALUE;
    rd_hit  = 1'b1;
    if (rd_is_slot) begin
      rd_word[adc_result_pkg::RES_MSB:adc_result_pkg::RES_LSB] = value_v[rd_idx];
      rd_word[adc_result_pkg::OVR_BIT]    = overrun_v[rd_idx];
      rd_word[adc_result_pkg::STORED_BIT] = stored_v[rd_idx];
    end else if (s_axi_araddr == adc_result_pkg::OFF_THRESHOLD) begin
      rd_word[adc_result_pkg::RES_MSB:adc_result_pkg::RES_LSB] = monitor0_level;
    end else if (s_axi_araddr == adc_result_pkg::OFF_MON_CONTROL) begin
      rd_word[adc_result_pkg::MON_EN_BIT]     = monitor0_enable;
      rd_word[adc_result_pkg::MON_LARGER_BIT] = monitor0_larger;
      rd_word[adc_result_pkg::MON_SEL_LSB +: adc_result_pkg::MON_SEL_W] = monitor0_reg_select;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // flags cleared by the read that returns them
  // AXI4-Lite reads are always full word, so slot seven needs no guard
  generate
    for (g = 0; g < N; g++) begin : g_clr
      assign read_clear_v[g] = ar_take & rd_is_slot & (rd_idx == 2'(g));
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= adc_result_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? adc_result_pkg::RESP_OKAY : adc_result_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : adc_result_regs

// ==== core/result_if.sv ====
// Interface carrying one result slot's deposit, read strobe and state
interface result_if;
  logic                               deposit;
  logic [adc_result_pkg::RES_W-1:0]   value_in;
  logic                               read_clear;
  logic [adc_result_pkg::RES_W-1:0]   value;
  logic                               stored;
  logic                               overrun;
  modport owner (input deposit, input value_in, input read_clear,
                 output value, output stored, output overrun);
  modport user  (output deposit, output value_in, output read_clear,
                 input value, input stored, input overrun);
endinterface : result_if

// ==== core/result_slot.sv ====
// One result slot: value, stored flag and overrun flag
module result_slot (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Slot port
  result_if.owner   slot
);
  logic next_stored;
  logic next_overrun;

  // deposit sets stored, winning over a read clear
  assign next_stored  = slot.deposit | (slot.stored & ~slot.read_clear);
  // unread overwrite sets overrun; it stays while unread
  assign next_overrun = (slot.deposit & slot.stored & ~slot.read_clear)
                      | (slot.overrun & ~slot.read_clear)
                      | (slot.deposit & slot.overrun);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot.value   <= '0;
      slot.stored  <= 1'b0;
      slot.overrun <= 1'b0;
    end else begin
      if (slot.deposit) begin
        slot.value <= slot.value_in;
      end
      slot.stored  <= next_stored;
      slot.overrun <= next_overrun;
    end
  end
endmodule : result_slot

// ==== tb/adc_result_assertions.sv ====
// Bus timing and monitor event assertions for the result register bank
module adc_result_assertions (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  // Converter strobes and monitor event
  input wire logic        slot6_deposit_i,
  input wire logic        slot7_deposit_i,
  input wire logic        priority_deposit_i,
  input wire logic        monitor0_event_o,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic any_deposit;
  assign any_deposit = slot6_deposit_i | slot7_deposit_i | priority_deposit_i;
  sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence aw_taken; s_axi_awvalid && s_axi_awready; endsequence
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  a_write_answer: assert property (aw_taken |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response not two cycles after address");
  a_resp_blocks_aw: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted during response");
  a_data_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during read data");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data stayed after handshake");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half of read data not zero");
  a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == adc_result_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_event_cause: assert property (monitor0_event_o |-> $past(any_deposit))
    else $error("monitor event without a deposit");
endmodule : adc_result_assertions

bind adc_result_regs adc_result_assertions u_adc_result_assertions (
  .core_clk_i, .rst_n_i, .slot6_deposit_i, .slot7_deposit_i, .priority_deposit_i,
  .monitor0_event_o, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

// ==== tb/conv_core_model.sv ====
// Converter core model depositing results into the three slots
module conv_core_model (
  // Clock
  input  wire logic core_clk_i,
  // Deposit strobes and shared value
  output logic [2:0] deposit_o,
  output logic [9:0] result_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    deposit_o = 3'h0;
    result_o  = 10'h3FF;
  end
  // Value line inverts after the strobe so a late sample never sees a stale copy
  task automatic put(input int slot, input logic [9:0] value, input int delay);
    repeat (delay) @(posedge core_clk_i);
    @(posedge core_clk_i);
    deposit_o[slot] <= 1'b1;
    result_o        <= value;
    @(posedge core_clk_i);
    deposit_o       <= 3'h0;
    result_o        <= ~value;
  endtask : put
endmodule : conv_core_model

// ==== tb/tb.sv ====
// Self-checking bench for the result register bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK  = adc_result_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = adc_result_pkg::RESP_SLVERR;
  localparam logic [7:0] TH  = adc_result_pkg::OFF_THRESHOLD;
  localparam logic [7:0] CT  = adc_result_pkg::OFF_MON_CONTROL;
  logic        core_clk_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, event_o;
  logic [7:0]  awaddr, araddr, adr [3];
  logic [31:0] wdata, rdata, w;
  logic [1:0]  bresp, rresp;
  logic [2:0]  dep;
  logic [3:0]  strb;
  logic [9:0]  res;
  int          fail_count, n_tests, cycles, thr, ctl, val [3], st [3], ov [3];
  adc_result_regs i_adc_result_regs (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .slot6_deposit_i(dep[0]),
    .slot6_result_i(res), .slot7_deposit_i(dep[1]), .slot7_result_i(res),
    .priority_deposit_i(dep[2]), .priority_result_i(res), .monitor0_event_o(event_o),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  conv_core_model u_core (.core_clk_i(core_clk_i), .deposit_o(dep), .result_o(res));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : wr
  // whole-word reads only, slot seven safe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge core_clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
  endtask : rd
  task automatic rres(input int s);
    rd(adr[s], 32'(val[s] << 6 | ov[s] << 1 | st[s]), OK);
    st[s] = 0;
    ov[s] = 0;
  endtask : rres
  task automatic dp(input int s, input int v);
    int hit;
    hit = ctl[0] && ctl[5:4] == s && (ctl[1] ? v > thr : v < thr);
    ov[s] = ov[s] | st[s];
    st[s] = 1;
    val[s] = v;
    u_core.put(s, 10'(v), $urandom_range(0, 2));
    @(negedge core_clk_i);
    chk(32'(event_o), 32'(hit));
  endtask : dp
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, rst_n_i} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    strb = 4'hF;
    adr = '{adc_result_pkg::OFF_SLOT_SIX, adc_result_pkg::OFF_SLOT_SEVEN,
            adc_result_pkg::OFF_PRIORITY};
    void'($urandom(32'hB075));
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, OK);
    rd(8'h18, 32'h0, ERR);
    for (int s = 0; s < 3; s++) begin
      repeat ($urandom_range(1, 3)) dp(s, $urandom_range(0, 1023));
      rres(s);
      wr(adr[s], $urandom, ERR);
      rres(s);
    end
    w = $urandom;
    wr(TH, w, OK);
    rd(TH, {16'h0, w[15:6], 6'h0}, OK);
    wr(TH, 32'h8000, OK);
    thr = 32'h200;
    // Threshold write without both low lanes is dropped
    strb <= 4'h1;
    wr(TH, 32'hFFC0, OK);
    rd(TH, 32'h8000, OK);
    strb <= 4'hF;
    for (int m = 0; m < 6; m++) begin
      ctl = (m % 3) << 4 | (m / 3) << 1 | 1;
      wr(CT, ctl, OK);
      rd(CT, ctl, OK);
      wr(TH, $urandom, OK);
      rd(TH, 32'h8000, OK);
      for (int v = 10'h1FF; v < 10'h202; v++) dp(m % 3, v);
      dp((m + 1) % 3, 10'h3FF);
      rres(m % 3);
      rres((m + 1) % 3);
    end
    // Select code three watches no register
    ctl = 32'h31;
    wr(CT, ctl, OK);
    rd(CT, ctl, OK);
    dp(0, 10'h000);
    dp(0, 10'h000);
    // Deposit and clearing read on one edge: the deposit wins
    fork
      rd(adr[0], 32'(val[0] << 6 | ov[0] << 1 | st[0]), OK);
      u_core.put(0, 10'h155, 0);
    join
    st[0] = 1;
    val[0] = 10'h155;
    rres(0);
    final_report();
  end
endmodule : tb
